// >>> verilog/uocf_top.sv
// USB OTG configuration registers and OTG / device event flags
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module uocf_top #(
   parameter int MS_CYCLES   = uocf_pkg::MS_CYC,
   parameter int IDLE_CYCLES = uocf_pkg::IDLE_CYC
) (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_sys_rst,
   input  wire uocf_pkg::uocf_bus_t  i_bus,
   output logic [15:0]               o_rdata,
   input  wire uocf_pkg::uocf_line_t i_line,
   input  wire logic                 i_xcvr_drive,
   input  wire logic                 i_chip_idle,
   input  wire logic                 i_stall_sent,
   input  wire logic                 i_token_done,
   input  wire logic                 i_sof_rx,
   input  wire logic                 i_sof_thresh,
   input  wire logic [7:0]           i_err_evt,
   output logic                      o_eye_test_en,
   output logic                      o_oe_n,
   output logic                      o_module_halt,
   output logic [15:0]               o_pp_ep_en,
   output logic                      o_vbus_pullup_en,
   output logic                      o_otg_irq,
   output logic                      o_fifo_advance
);
   localparam int CW = uocf_pkg::CNT_W;

   function automatic logic [CW-1:0] sat_inc(
      input logic [CW-1:0] c,
      input int            lim);
      logic [CW-1:0] r;
      r = c;
      if (c < CW'(lim)) begin
         r = c + 1'b1;
      end
      return r;
   endfunction

   function automatic logic [15:0] pp_decode(input logic [1:0] m);
      logic [15:0] r;
      r = 16'h0000;
      case (m)
         uocf_pkg::PP_NONE: r = 16'h0000;
         uocf_pkg::PP_EP0:  r = 16'h0001;
         uocf_pkg::PP_ALL:  r = 16'hffff;
         default:           r = 16'hfffe;
      endcase
      return r;
   endfunction

   // Pin synchroniser: a change counts once stages two and three agree
   // Three stages keep a metastable first stage away from the counters
   uocf_pkg::uocf_line_t s1_q;
   uocf_pkg::uocf_line_t s2_q;
   uocf_pkg::uocf_line_t s3_q;
   uocf_pkg::uocf_line_t ln_q;
   uocf_pkg::uocf_line_t ln_prev_q;
   logic                 ln_vld_q;

   always_ff @(posedge i_ref_clk) begin
      s1_q <= i_line;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         ln_q      <= '0;
         ln_prev_q <= '0;
         ln_vld_q  <= 1'b0;
      end else if (!ln_vld_q) begin
         // Seed both copies from the pins so leaving reset is no edge
         ln_q      <= s3_q;
         ln_prev_q <= s3_q;
         ln_vld_q  <= 1'b1;
      end else begin
         if (s2_q == s3_q) begin
            ln_q <= s3_q;
         end
         ln_prev_q <= ln_q;
      end
   end

   // Edges are ignored until the filtered copy has a real history
   uocf_pkg::uocf_line_t ln_chg;
   assign ln_chg = ln_vld_q ? (ln_q ^ ln_prev_q) : '0;

   // Registers
   logic [7:0] cfg1_q;
   logic [7:0] cfg2_q;
   logic [7:0] otg_if_q;
   logic [7:0] otg_ie_q;
   logic [7:0] dev_if_q;
   logic [7:0] err_ie_q;

   logic       wr_cfg1;
   logic       wr_cfg2;
   logic       wr_otg_if;
   logic       wr_otg_ie;
   logic       wr_dev_if;
   logic       wr_err_ie;

   // Unmapped indices match no branch, so such writes are dropped
   always_comb begin
      wr_cfg1   = 1'b0;
      wr_cfg2   = 1'b0;
      wr_otg_if = 1'b0;
      wr_otg_ie = 1'b0;
      wr_dev_if = 1'b0;
      wr_err_ie = 1'b0;
      if (!i_bus.wr) begin
         wr_cfg1 = 1'b0;
      end else if (i_bus.addr == uocf_pkg::REG_CFG1) begin
         wr_cfg1 = 1'b1;
      end else if (i_bus.addr == uocf_pkg::REG_CFG2) begin
         wr_cfg2 = 1'b1;
      end else if (i_bus.addr == uocf_pkg::REG_OTG_IF) begin
         wr_otg_if = 1'b1;
      end else if (i_bus.addr == uocf_pkg::REG_OTG_IE) begin
         wr_otg_ie = 1'b1;
      end else if (i_bus.addr == uocf_pkg::REG_DEV_IF) begin
         wr_dev_if = 1'b1;
      end else if (i_bus.addr == uocf_pkg::REG_ERR_IE) begin
         wr_err_ie = 1'b1;
      end
   end

   // A bit-wise write cannot name one flag, so it wipes every set flag
   logic [7:0] clr_val;
   assign clr_val = i_bus.bitop ? 8'hff : i_bus.wdata[7:0];

   // Reserved bits of the second config word are not writable
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         cfg1_q   <= uocf_pkg::REG_RESET;
         cfg2_q   <= uocf_pkg::REG_RESET;
         otg_ie_q <= uocf_pkg::REG_RESET;
         err_ie_q <= uocf_pkg::REG_RESET;
      end else begin
         if (wr_cfg1) begin
            cfg1_q <= i_bus.wdata[7:0] & uocf_pkg::CFG1_MASK;
         end
         if (wr_cfg2) begin
            cfg2_q <= i_bus.wdata[7:0] & uocf_pkg::CFG2_MASK;
         end
         if (wr_otg_ie) begin
            otg_ie_q <= i_bus.wdata[7:0] & uocf_pkg::OTG_MASK;
         end
         if (wr_err_ie) begin
            err_ie_q <= i_bus.wdata[7:0] & uocf_pkg::ERR_IE_MASK;
         end
      end
   end

   // Millisecond timer, free-running from reset; the first tick is not
   // aligned to any bus event
   logic [CW-1:0] ms_cnt_q;
   logic          ms_tick;
   assign ms_tick = (ms_cnt_q == CW'(MS_CYCLES - 1));

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || ms_tick) begin
         ms_cnt_q <= '0;
      end else begin
         ms_cnt_q <= ms_cnt_q + 1'b1;
      end
   end

   // Line state stability over 1 ms, compared with the last stable one
   logic [1:0]    lst_now;
   logic [1:0]    lst_run_q;
   logic [1:0]    lst_last_q;
   logic [CW-1:0] lst_cnt_q;
   logic          lst_evt;
   assign lst_now = {ln_q.se0, ln_q.j_state_live};
   assign lst_evt = (lst_cnt_q == CW'(MS_CYCLES - 1))
                    && (lst_run_q == lst_now)
                    && (lst_now != lst_last_q);

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         lst_run_q  <= 2'h0;
         lst_last_q <= 2'h0;
         lst_cnt_q  <= '0;
      end else if (lst_now != lst_run_q) begin
         lst_run_q <= lst_now;
         lst_cnt_q <= '0;
      end else begin
         lst_cnt_q <= sat_inc(lst_cnt_q, MS_CYCLES);
         if (lst_evt) begin
            lst_last_q <= lst_now;
         end
      end
   end

   // Bus reset (SE0), resume (K) and idle (J) duration detectors
   logic          k_state;
   logic          j_state;
   logic [CW-1:0] rst_cnt_q;
   logic [CW-1:0] k_cnt_q;
   logic [CW-1:0] idl_cnt_q;
   logic          rst_evt;
   logic          res_evt;
   logic          idl_evt;
   // Nothing counts until the filtered copy has been seeded from the pins
   assign k_state = ln_vld_q && !ln_q.se0 && !ln_q.j_state_live;
   assign j_state = ln_vld_q && !ln_q.se0 && ln_q.j_state_live;
   // Each fires once per episode; counters saturate one past the limit
   assign rst_evt = (rst_cnt_q == CW'(uocf_pkg::STEADY_CYC - 1))
                    && ln_q.se0;
   assign res_evt = (k_cnt_q == CW'(uocf_pkg::STEADY_CYC - 1))
                    && k_state;
   assign idl_evt = (idl_cnt_q == CW'(IDLE_CYCLES - 1))
                    && j_state;

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !ln_q.se0) begin
         rst_cnt_q <= '0;
      end else begin
         rst_cnt_q <= sat_inc(rst_cnt_q, uocf_pkg::STEADY_CYC);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !k_state) begin
         k_cnt_q <= '0;
      end else begin
         k_cnt_q <= sat_inc(k_cnt_q, uocf_pkg::STEADY_CYC);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !j_state) begin
         idl_cnt_q <= '0;
      end else begin
         idl_cnt_q <= sat_inc(idl_cnt_q, IDLE_CYCLES);
      end
   end

   // OTG event sets
   // The ID pin is not bus activity; only data lines and comparators are
   logic [7:0] otg_set;
   always_comb begin
      otg_set = 8'h00;
      otg_set[uocf_pkg::OTG_ID]   = ln_chg.id;
      otg_set[uocf_pkg::OTG_MS]   = ms_tick;
      otg_set[uocf_pkg::OTG_LST]  = lst_evt;
      otg_set[uocf_pkg::OTG_ACT]  = ln_chg.dp || ln_chg.dm
                                    || ln_chg.a_sess_end
                                    || ln_chg.b_sess_end
                                    || ln_chg.a_vbus_vld;
      otg_set[uocf_pkg::OTG_SESV] = ln_chg.a_sess_end;
      otg_set[uocf_pkg::OTG_BSE]  = ln_chg.b_sess_end;
      otg_set[uocf_pkg::OTG_AVV]  = ln_chg.a_vbus_vld;
   end

   // Device event sets
   logic [7:0] dev_set;
   always_comb begin
      dev_set = 8'h00;
      dev_set[uocf_pkg::DEV_STALL] = i_stall_sent;
      dev_set[uocf_pkg::DEV_RES]   = res_evt;
      dev_set[uocf_pkg::DEV_IDLE]  = idl_evt;
      dev_set[uocf_pkg::DEV_TRN]   = i_token_done;
      dev_set[uocf_pkg::DEV_SOF]   = i_sof_rx || i_sof_thresh;
      dev_set[uocf_pkg::DEV_ERR]   = |(i_err_evt & err_ie_q);
      dev_set[uocf_pkg::DEV_RST]   = rst_evt;
   end

   logic [7:0] otg_clr;
   logic [7:0] dev_clr;
   assign otg_clr = wr_otg_if ? clr_val : 8'h00;
   assign dev_clr = wr_dev_if ? clr_val : 8'h00;

   // Set is applied after clear so a coincident event survives
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         otg_if_q <= uocf_pkg::REG_RESET;
         dev_if_q <= uocf_pkg::REG_RESET;
      end else begin
         otg_if_q <= ((otg_if_q & ~otg_clr) | otg_set)
                     & uocf_pkg::OTG_MASK;
         dev_if_q <= ((dev_if_q & ~dev_clr) | dev_set)
                     & uocf_pkg::DEV_MASK;
      end
   end

   // Status FIFO moves on only when a set token flag is really cleared
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_fifo_advance <= 1'b0;
      end else begin
         o_fifo_advance <= dev_if_q[uocf_pkg::DEV_TRN]
                           && dev_clr[uocf_pkg::DEV_TRN];
      end
   end

   // Read port: data stands only in the cycle after the strobe
   // Unmapped indices read zero, like unimplemented bits
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst || !i_bus.rd) begin
         o_rdata <= 16'h0000;
      end else if (i_bus.addr == uocf_pkg::REG_CFG1) begin
         o_rdata <= {8'h00, cfg1_q};
      end else if (i_bus.addr == uocf_pkg::REG_CFG2) begin
         o_rdata <= {8'h00, cfg2_q};
      end else if (i_bus.addr == uocf_pkg::REG_OTG_IF) begin
         o_rdata <= {8'h00, otg_if_q};
      end else if (i_bus.addr == uocf_pkg::REG_OTG_IE) begin
         o_rdata <= {8'h00, otg_ie_q};
      end else if (i_bus.addr == uocf_pkg::REG_DEV_IF) begin
         o_rdata <= {8'h00, dev_if_q};
      end else if (i_bus.addr == uocf_pkg::REG_ERR_IE) begin
         o_rdata <= {8'h00, err_ie_q};
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // Configuration outputs
   // Registered, so each output follows its cause one cycle late
   logic oe_mon_act;
   assign oe_mon_act = cfg1_q[uocf_pkg::CFG1_OEM]
                       && cfg2_q[uocf_pkg::CFG2_XDIS];

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         o_eye_test_en    <= 1'b0;
         o_oe_n           <= 1'b1;
         o_module_halt    <= 1'b0;
         o_pp_ep_en       <= 16'h0000;
         o_vbus_pullup_en <= 1'b0;
         o_otg_irq        <= 1'b0;
      end else begin
         o_eye_test_en    <= cfg1_q[uocf_pkg::CFG1_EYE];
         o_oe_n           <= !(oe_mon_act && i_xcvr_drive);
         o_module_halt    <= cfg1_q[uocf_pkg::CFG1_SIDL]
                             && i_chip_idle;
         o_pp_ep_en       <= pp_decode(
                             cfg1_q[uocf_pkg::CFG1_PPB +: 2]);
         // Changing this while powered is left to software
         o_vbus_pullup_en <= cfg2_q[uocf_pkg::CFG2_PUVB];
         o_otg_irq        <= |(otg_if_q & otg_ie_q);
      end
   end
endmodule

// >>> include/uocf_pkg.sv
// Package for the USB OTG configuration and event-flag block
package uocf_pkg;
   // Register indices on the plain register port
   localparam logic [2:0] REG_CFG1   = 3'h0;
   localparam logic [2:0] REG_CFG2   = 3'h1;
   localparam logic [2:0] REG_OTG_IF = 3'h2;
   localparam logic [2:0] REG_OTG_IE = 3'h3;
   localparam logic [2:0] REG_DEV_IF = 3'h4;
   localparam logic [2:0] REG_ERR_IE = 3'h5;
   // Writable / implemented bit masks
   localparam logic [7:0] CFG1_MASK   = 8'hd3;
   localparam logic [7:0] CFG2_MASK   = 8'h11;
   localparam logic [7:0] OTG_MASK    = 8'hfd;
   localparam logic [7:0] DEV_MASK    = 8'hbf;
   localparam logic [7:0] ERR_IE_MASK = 8'hbf;
   localparam logic [7:0] REG_RESET   = 8'h00;
   // Config fields
   localparam int CFG1_EYE  = 7;
   localparam int CFG1_OEM  = 6;
   localparam int CFG1_SIDL = 4;
   localparam int CFG1_PPB  = 0;
   localparam int CFG2_PUVB = 4;
   localparam int CFG2_XDIS = 0;
   // OTG flag positions
   localparam int OTG_ID    = 7;
   localparam int OTG_MS    = 6;
   localparam int OTG_LST   = 5;
   localparam int OTG_ACT   = 4;
   localparam int OTG_SESV  = 3;
   localparam int OTG_BSE   = 2;
   localparam int OTG_AVV   = 0;
   // Device flag positions
   localparam int DEV_STALL = 7;
   localparam int DEV_RES   = 5;
   localparam int DEV_IDLE  = 4;
   localparam int DEV_TRN   = 3;
   localparam int DEV_SOF   = 2;
   localparam int DEV_ERR   = 1;
   localparam int DEV_RST   = 0;
   // Ping-pong modes
   localparam logic [1:0] PP_NONE = 2'h0;
   localparam logic [1:0] PP_EP0  = 2'h1;
   localparam logic [1:0] PP_ALL  = 2'h2;
   localparam logic [1:0] PP_EP1P = 2'h3;
   // Timing
   localparam int CLK_PS     = 8000;
   localparam int MS_PS      = 1000000000;
   localparam int RST_MIN_PS = 2500000;
   localparam int IDLE_MS    = 3;
   localparam int MS_CYC     = MS_PS / CLK_PS;
   localparam int STEADY_CYC = (RST_MIN_PS + CLK_PS - 1) / CLK_PS;
   localparam int IDLE_CYC   = IDLE_MS * MS_CYC;
   localparam int CNT_W      = 20;

   typedef struct packed {
      logic se0;
      logic j_state_live;
      logic dp;
      logic dm;
      logic id;
      logic a_sess_end;
      logic b_sess_end;
      logic a_vbus_vld;
   } uocf_line_t;

   typedef struct packed {
      logic [2:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        bitop;
      logic        rd;
   } uocf_bus_t;
endpackage

// >>> sim/uocf_asserts.sv
// Concurrent checks on the configuration outputs and register port
`timescale 1ns/1ns
module uocf_asserts (
   input wire logic                i_ref_clk,
   input wire logic                i_sys_rst,
   input wire uocf_pkg::uocf_bus_t i_bus,
   input wire logic [15:0]         o_rdata,
   input wire logic                i_xcvr_drive,
   input wire logic                i_chip_idle,
   input wire logic                o_eye_test_en,
   input wire logic                o_oe_n,
   input wire logic                o_module_halt,
   input wire logic [15:0]         o_pp_ep_en,
   input wire logic                o_vbus_pullup_en,
   input wire logic                o_fifo_advance
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   logic [7:0]  cfg1_q;
   logic [7:0]  cfg2_q;
   logic [17:0] now_v;
   logic [17:0] prev1_q;
   logic [17:0] prev2_q;
   logic        quiet;
   logic [15:0] pp_exp;

   // Shadow copy of the config registers, written only by the bus
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         cfg1_q <= 8'h00;
         cfg2_q <= 8'h00;
      end else if (i_bus.wr && i_bus.addr == uocf_pkg::REG_CFG1) begin
         cfg1_q <= i_bus.wdata[7:0] & uocf_pkg::CFG1_MASK;
      end else if (i_bus.wr && i_bus.addr == uocf_pkg::REG_CFG2) begin
         cfg2_q <= i_bus.wdata[7:0] & uocf_pkg::CFG2_MASK;
      end
   end

   // Outputs are judged only once causes held two cycles, so either
   // one or two register stages in the design are accepted
   assign now_v = {cfg1_q, cfg2_q, i_chip_idle, i_xcvr_drive};
   assign quiet = (now_v == prev1_q) && (prev1_q == prev2_q);
   always_ff @(posedge i_ref_clk) begin
      prev1_q <= now_v;
      prev2_q <= prev1_q;
   end

   always_comb begin
      case (cfg1_q[1:0])
         uocf_pkg::PP_NONE: pp_exp = 16'h0000;
         uocf_pkg::PP_EP0:  pp_exp = 16'h0001;
         uocf_pkg::PP_ALL:  pp_exp = 16'hffff;
         default:           pp_exp = 16'hfffe;
      endcase
   end

   a_eye_follow:
      assert property (quiet |-> o_eye_test_en == cfg1_q[7])
      else $error("eye test output differs from config");
   a_oe_active:
      assert property (quiet && cfg2_q[0] |->
         o_oe_n == !(cfg1_q[6] && i_xcvr_drive))
      else $error("output enable monitor level wrong");
   a_oe_gated:
      assert property (quiet && !cfg2_q[0] |-> o_oe_n)
      else $error("output enable low without transceiver disable");
   a_halt_idle:
      assert property (quiet |-> o_module_halt == (cfg1_q[4] && i_chip_idle))
      else $error("module halt wrong");
   a_pp_map:
      assert property (quiet |-> o_pp_ep_en == pp_exp)
      else $error("ping-pong endpoint map wrong");
   a_pullup_follow:
      assert property (quiet |-> o_vbus_pullup_en == cfg2_q[4])
      else $error("vbus pull-up output differs from config");
   a_fifo_cause:
      assert property (o_fifo_advance |-> $past(i_bus.wr)
         && $past(i_bus.addr) == uocf_pkg::REG_DEV_IF)
      else $error("status advance without a flag write");
   a_fifo_pulse:
      assert property (o_fifo_advance |=> !o_fifo_advance)
      else $error("status advance longer than one cycle");
   a_rdata_idle:
      assert property (!$past(i_bus.rd) |-> o_rdata == 16'h0000)
      else $error("read data outside the read answer cycle");
   a_rdata_high:
      assert property (o_rdata[15:8] == 8'h00)
      else $error("upper read byte not zero");
endmodule

bind uocf_top uocf_asserts u_chk (.i_ref_clk, .i_sys_rst, .i_bus, .o_rdata,
   .i_xcvr_drive, .i_chip_idle, .o_eye_test_en, .o_oe_n, .o_module_halt,
   .o_pp_ep_en, .o_vbus_pullup_en, .o_fifo_advance);

// >>> sim/uocf_bus_peer.sv
// Bus-side peer model driving line levels and OTG comparators
`timescale 1ns/1ns
module uocf_bus_peer (
   input  wire logic            i_ref_clk,
   output uocf_pkg::uocf_line_t o_line
);
   // Idle full-speed bus shows J; ID high means no A-plug inserted
   initial begin
      o_line = 8'h68;
   end

   // State 0 is J, 1 is K, 2 is single-ended zero
   task automatic drive_state(input logic [1:0] st);
      @(posedge i_ref_clk);
      o_line.se0          <= (st == 2'd2);
      o_line.j_state_live <= (st == 2'd0);
      o_line.dp           <= (st == 2'd0);
      o_line.dm           <= (st == 2'd1);
   endtask

   // Mask order: id, A session end, B session end, A vbus valid
   task automatic flip_pins(input logic [3:0] m);
      @(posedge i_ref_clk);
      o_line[3:0] <= o_line[3:0] ^ m;
   endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the OTG configuration and event-flag block
`timescale 1ns/1ns
module testbench;
   localparam int MS_N   = 50;
   localparam int IDLE_N = 100;
   localparam int RST_N  = uocf_pkg::STEADY_CYC;
   localparam logic [7:0]  CFGS [4] = '{8'h00, 8'h51, 8'h82, 8'hd3};
   localparam logic [15:0] PPS [4] = '{16'h0000, 16'h0001, 16'hffff,
                                       16'hfffe};
   logic                 clk;
   logic                 rst;
   uocf_pkg::uocf_bus_t  bus;
   uocf_pkg::uocf_line_t line;
   logic [15:0]          rdata;
   logic [15:0]          pp_en;
   logic [15:0]          v;
   logic [7:0]           err;
   logic                 drive, idle, stall, tok, sof, thr;
   logic                 eye, oe_n, halt, pull, irq, adv;
   int                   fails, num_checks, cyc;

   uocf_top #(.MS_CYCLES(MS_N), .IDLE_CYCLES(IDLE_N)) uut (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_rdata(rdata),
      .i_line(line), .i_xcvr_drive(drive), .i_chip_idle(idle),
      .i_stall_sent(stall), .i_token_done(tok), .i_sof_rx(sof),
      .i_sof_thresh(thr), .i_err_evt(err), .o_eye_test_en(eye),
      .o_oe_n(oe_n), .o_module_halt(halt), .o_pp_ep_en(pp_en),
      .o_vbus_pullup_en(pull), .o_otg_irq(irq), .o_fifo_advance(adv));
   uocf_bus_peer peer (.i_ref_clk(clk), .o_line(line));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d,
                     input logic b);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, bitop: b, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Raises the chosen event inputs {stall, tok, sof, thr} for one cycle
   task automatic pulse(input logic [3:0] m, input logic [7:0] e);
      {stall, tok, sof, thr} <= m;
      err <= e;
      @(posedge clk);
      {stall, tok, sof, thr} <= 4'h0;
      err <= 8'h00;
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         fails++;
         summarize();
      end
   end

   initial begin
      rst = 1'b1;
      bus = '0;
      drive = 1'b0;
      idle  = 1'b0;
      {stall, tok, sof, thr} = 4'h0;
      err = 8'h00;
      tick(6);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd(i[2:0], v);
         check(v, 16'h0000);
      end
      check({15'h0, oe_n}, 16'h0001);
      check({15'h0, pull}, 16'h0000);
      wr(uocf_pkg::REG_CFG1, 16'hffff, 1'b0);
      rd(uocf_pkg::REG_CFG1, v);
      check(v, {8'h00, uocf_pkg::CFG1_MASK});
      // Pull-up set once here and never toggled afterwards
      wr(uocf_pkg::REG_CFG2, 16'hffff, 1'b0);
      drive <= 1'b1;
      idle  <= 1'b1;
      rd(uocf_pkg::REG_CFG2, v);
      check(v, {8'h00, uocf_pkg::CFG2_MASK});
      for (int i = 0; i < 4; i++) begin
         wr(uocf_pkg::REG_CFG1, {8'h00, CFGS[i]}, 1'b0);
         tick(3);
         #1;
         check(pp_en, PPS[i]);
         check({15'h0, eye}, {15'h0, CFGS[i][7]});
         check({15'h0, halt}, {15'h0, CFGS[i][4]});
         check({15'h0, oe_n}, {15'h0, !CFGS[i][6]});
         check({15'h0, pull}, 16'h0001);
      end
      wr(uocf_pkg::REG_CFG2, 16'h0010, 1'b0);
      tick(3);
      #1 check({15'h0, oe_n}, 16'h0001);
      wr(uocf_pkg::REG_CFG2, 16'h0011, 1'b0);
      drive <= 1'b0;
      idle  <= 1'b0;
      tick(3);
      #1 check({14'h0, oe_n, halt}, 16'h0002);
      tick(IDLE_N + 20);
      wr(uocf_pkg::REG_DEV_IF, 16'h0001, 1'b1);
      wr(uocf_pkg::REG_ERR_IE, 16'h0001, 1'b0);
      pulse(4'he, 8'h02);
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v, 16'h008c);
      wr(uocf_pkg::REG_DEV_IF, 16'h0004, 1'b0);
      pulse(4'h1, 8'h01);
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v, 16'h008e);
      wr(uocf_pkg::REG_DEV_IF, 16'h0004, 1'b0);
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v, 16'h008a);
      wr(uocf_pkg::REG_DEV_IF, 16'h0008, 1'b0);
      #1 check({15'h0, adv}, 16'h0001);
      // Clear and a new stall event meet in one cycle
      @(posedge clk);
      bus <= '{addr: uocf_pkg::REG_DEV_IF, wdata: 16'h0080, wr: 1'b1,
               bitop: 1'b0, rd: 1'b0};
      pulse(4'h8, 8'h00);
      bus.wr <= 1'b0;
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v, 16'h0082);
      wr(uocf_pkg::REG_DEV_IF, 16'h0001, 1'b1);
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v, 16'h0000);
      peer.drive_state(2'd2);
      tick(RST_N + 12);
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v & 16'h0031, 16'h0001);
      wr(uocf_pkg::REG_DEV_IF, 16'h0001, 1'b0);
      tick(RST_N + 12);
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v & 16'h0031, 16'h0000);
      peer.drive_state(2'd1);
      tick(RST_N + 12);
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v & 16'h0031, 16'h0020);
      peer.drive_state(2'd0);
      tick(IDLE_N + 12);
      rd(uocf_pkg::REG_DEV_IF, v);
      check(v & 16'h0031, 16'h0030);
      wr(uocf_pkg::REG_OTG_IF, 16'h0001, 1'b1);
      peer.flip_pins(4'h8);
      tick(8);
      rd(uocf_pkg::REG_OTG_IF, v);
      check(v & 16'h009d, 16'h0080);
      check({15'h0, irq}, 16'h0000);
      wr(uocf_pkg::REG_OTG_IE, 16'h0080, 1'b0);
      tick(2);
      #1 check({15'h0, irq}, 16'h0001);
      peer.flip_pins(4'h7);
      tick(8);
      rd(uocf_pkg::REG_OTG_IF, v);
      check(v & 16'h009d, 16'h009d);
      wr(uocf_pkg::REG_OTG_IF, 16'h0060, 1'b0);
      peer.drive_state(2'd1);
      tick(MS_N + 8);
      rd(uocf_pkg::REG_OTG_IF, v);
      check(v & 16'h0060, 16'h0060);
      wr(uocf_pkg::REG_OTG_IF, 16'h0020, 1'b0);
      tick(MS_N + 8);
      rd(uocf_pkg::REG_OTG_IF, v);
      check(v & 16'h0020, 16'h0000);
      summarize();
   end
endmodule
